/* imp_pkg.sv */
// constants, encodings and state type for the indexed move and push execution block
`default_nettype none
package imp_pkg;
  // ***********************************************************
  // widths
  // ***********************************************************
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned OFF_W  = 7;
  localparam int unsigned WORD_W = 16;

  // ***********************************************************
  // instruction word fields
  // ***********************************************************
  localparam int unsigned MOVE_OP_POS = 7;
  localparam logic [8:0]  MOVE_OP     = 9'h1d7;
  localparam int unsigned SECOND_POS  = 12;
  localparam logic [3:0]  SECOND_OP   = 4'hf;
  localparam int unsigned PUSH_OP_POS = 8;
  localparam logic [7:0]  PUSH_OP     = 8'hfa;

  // ***********************************************************
  // reset values and fixed data
  // ***********************************************************
  localparam logic [ADDR_W-1:0] PTR_RST   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_RST  = 12'h000;
  localparam logic [DATA_W-1:0] DATA_RST  = 8'h00;
  localparam logic [DATA_W-1:0] IND_DATA  = 8'h00;
  localparam logic [ADDR_W-1:0] PTR_STEP  = 12'h001;

  // ***********************************************************
  // indirect-addressing register addresses
  // ***********************************************************
  localparam logic [ADDR_W-1:0] IND_ADDR0 = 12'hffd;
  localparam logic [ADDR_W-1:0] IND_ADDR1 = 12'hffe;
  localparam logic [ADDR_W-1:0] IND_ADDR2 = 12'hfff;

  // ***********************************************************
  // sequencer states
  // ***********************************************************
  typedef enum logic [1:0] {
    IMP_IDLE  = 2'b00,
    IMP_DST   = 2'b01,
    IMP_WRITE = 2'b11
  } imp_state_t;
endpackage : imp_pkg
`default_nettype wire

/* imp_addr_add.sv */
// stack pointer plus unsigned offset address adder
`default_nettype none
module imp_addr_add
  import imp_pkg::*;
(
  input  wire logic [ADDR_W-1:0] i_base,
  input  wire logic [OFF_W-1:0]  i_off,
  output logic      [ADDR_W-1:0] o_addr,
  output logic                   o_ind
);
  // ***********************************************************
  // address forming
  // ***********************************************************
  // zero-extended offset add
  assign o_addr = i_base + {{(ADDR_W - OFF_W){1'b0}}, i_off};
  assign o_ind  = (o_addr == IND_ADDR0) || (o_addr == IND_ADDR1) || (o_addr == IND_ADDR2);
endmodule : imp_addr_add
`default_nettype wire

/* imp_exec.sv */
// execution sequencer for the indexed move and push literal instructions
`default_nettype none
module imp_exec
  import imp_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RST_N,
  input  wire logic              I_INSN_VALID,
  input  wire logic [WORD_W-1:0] I_INSN_WORD,
  output logic                   O_INSN_READY,
  input  wire logic              I_PTR_WE,
  input  wire logic [ADDR_W-1:0] I_PTR_WDATA,
  output logic      [ADDR_W-1:0] O_PTR,
  output logic      [ADDR_W-1:0] O_MEM_ADDR,
  output logic                   O_MEM_RE,
  output logic                   O_MEM_WE,
  output logic      [DATA_W-1:0] O_MEM_WDATA,
  input  wire logic [DATA_W-1:0] I_MEM_RDATA,
  output logic                   O_DONE,
  output logic                   O_MOVE_NOP
);
  // ***********************************************************
  // state
  // ***********************************************************
  imp_state_t        state_reg;
  imp_state_t        state_next;
  logic [ADDR_W-1:0] ptr_reg;
  logic [ADDR_W-1:0] ptr_next;
  logic [ADDR_W-1:0] addr_reg;
  logic [ADDR_W-1:0] addr_next;
  logic              re_reg;
  logic              re_next;
  logic              we_reg;
  logic              we_next;
  logic [DATA_W-1:0] wdata_reg;
  logic [DATA_W-1:0] wdata_next;
  logic              src_ind_reg;
  logic              src_ind_next;
  logic              dst_ind_reg;
  logic              dst_ind_next;
  logic [ADDR_W-1:0] dst_addr_reg;
  logic [ADDR_W-1:0] dst_addr_next;
  logic              done_reg;
  logic              done_next;
  logic              nop_reg;
  logic              nop_next;

  // ***********************************************************
  // decode
  // ***********************************************************
  wire logic              take;
  wire logic              is_move;
  wire logic              is_push;
  wire logic              is_second;
  wire logic              move_start;
  wire logic              push_go;
  wire logic              dst_take;
  wire logic [OFF_W-1:0]  word_off;
  wire logic [DATA_W-1:0] word_lit;
  wire logic [ADDR_W-1:0] src_addr;
  wire logic              src_ind;
  wire logic [ADDR_W-1:0] dst_addr;
  wire logic              dst_ind;
  wire logic [DATA_W-1:0] move_data;

  // the write slot owns the memory port, so nothing new is taken there
  assign O_INSN_READY = (state_reg != IMP_WRITE);
  assign take         = I_INSN_VALID && O_INSN_READY;
  assign is_move      = (I_INSN_WORD[WORD_W-1:MOVE_OP_POS] == MOVE_OP);
  assign is_push      = (I_INSN_WORD[WORD_W-1:PUSH_OP_POS] == PUSH_OP);
  assign is_second    = (I_INSN_WORD[WORD_W-1:SECOND_POS] == SECOND_OP);
  assign word_off     = I_INSN_WORD[OFF_W-1:0];
  assign word_lit     = I_INSN_WORD[DATA_W-1:0];
  // move needs two words, push one
  assign move_start   = take && (state_reg == IMP_IDLE) && is_move;
  assign push_go      = take && (state_reg == IMP_IDLE) && is_push;
  // words that are not a second word are left for the rest of the core
  assign dst_take     = take && (state_reg == IMP_DST) && is_second;

  // ***********************************************************
  // address adders
  // ***********************************************************
  // both use the live pointer; push_go is gated to IMP_IDLE, so a push between words is impossible by construction
  imp_addr_add u_src_add (
    .i_base (ptr_reg),
    .i_off  (word_off),
    .o_addr (src_addr),
    .o_ind  (src_ind)
  );

  imp_addr_add u_dst_add (
    .i_base (ptr_reg),
    .i_off  (word_off),
    .o_addr (dst_addr),
    .o_ind  (dst_ind)
  );

  assign move_data = src_ind_reg ? IND_DATA : I_MEM_RDATA;

  // ***********************************************************
  // sequencer
  // ***********************************************************
  always_comb begin
    state_next    = state_reg;
    addr_next     = addr_reg;
    re_next       = 1'b0;
    we_next       = 1'b0;
    wdata_next    = wdata_reg;
    src_ind_next  = src_ind_reg;
    dst_ind_next  = dst_ind_reg;
    dst_addr_next = dst_addr_reg;
    done_next     = 1'b0;
    nop_next      = 1'b0;
    case (state_reg)
      IMP_IDLE: begin
        if (move_start) begin
          // first cycle forms source and reads it, unless it is an indirect register
          addr_next    = src_addr;
          re_next      = !src_ind;
          src_ind_next = src_ind;
          state_next   = IMP_DST;
        end else if (push_go) begin
          addr_next  = ptr_reg;
          we_next    = 1'b1;
          wdata_next = word_lit;
          done_next  = 1'b1;
        end
      end
      IMP_DST: begin
        if (dst_take) begin
          dst_addr_next = dst_addr;
          dst_ind_next  = dst_ind;
          state_next    = IMP_WRITE;
        end
      end
      IMP_WRITE: begin
        addr_next  = dst_addr_reg;
        we_next    = !dst_ind_reg;
        wdata_next = move_data;
        nop_next   = dst_ind_reg;
        done_next  = 1'b1;
        state_next = IMP_IDLE;
      end
      default: begin
        state_next = IMP_IDLE;
      end
    endcase
  end

  // ***********************************************************
  // stack pointer
  // ***********************************************************
  // full 12-bit decrement after the store
  assign ptr_next = push_go  ? (ptr_reg - PTR_STEP) :
                    I_PTR_WE ? I_PTR_WDATA : ptr_reg;

  // ***********************************************************
  // registers
  // ***********************************************************
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_reg    <= IMP_IDLE;
      ptr_reg      <= PTR_RST;
      addr_reg     <= ADDR_RST;
      re_reg       <= 1'b0;
      we_reg       <= 1'b0;
      wdata_reg    <= DATA_RST;
      src_ind_reg  <= 1'b0;
      dst_ind_reg  <= 1'b0;
      dst_addr_reg <= ADDR_RST;
      done_reg     <= 1'b0;
      nop_reg      <= 1'b0;
    end else begin
      state_reg    <= state_next;
      ptr_reg      <= ptr_next;
      addr_reg     <= addr_next;
      re_reg       <= re_next;
      we_reg       <= we_next;
      wdata_reg    <= wdata_next;
      src_ind_reg  <= src_ind_next;
      dst_ind_reg  <= dst_ind_next;
      dst_addr_reg <= dst_addr_next;
      done_reg     <= done_next;
      nop_reg      <= nop_next;
    end
  end

  // ***********************************************************
  // outputs
  // ***********************************************************
  // no flag port exists, status flags are untouched
  assign O_PTR       = ptr_reg;
  assign O_MEM_ADDR  = addr_reg;
  assign O_MEM_RE    = re_reg;
  assign O_MEM_WE    = we_reg;
  assign O_MEM_WDATA = wdata_reg;
  assign O_DONE      = done_reg;
  assign O_MOVE_NOP  = nop_reg;
endmodule : imp_exec
`default_nettype wire

/* imp_exec_asserts.sv */
// assertion checker for the indexed move and push execution block
`default_nettype none
module imp_exec_asserts
  import imp_pkg::*;
(
  input wire logic [DATA_W-1:0] I_MEM_RDATA,
  input wire logic              I_CLK,
  input wire logic              I_RST_N,
  input wire logic              I_INSN_VALID,
  input wire logic [WORD_W-1:0] I_INSN_WORD,
  input wire logic              O_INSN_READY,
  input wire logic [ADDR_W-1:0] O_PTR,
  input wire logic [ADDR_W-1:0] O_MEM_ADDR,
  input wire logic              O_MEM_RE,
  input wire logic              O_MEM_WE,
  input wire logic [DATA_W-1:0] O_MEM_WDATA,
  input wire logic              O_DONE,
  input wire logic              O_MOVE_NOP
);
  timeunit 1ns;
  timeprecision 1ps;
  // ***************************************
  // decode of taken words
  // ***************************************
  logic              wait_reg;
  logic              src_ind_reg;
  logic              take, push_take, mv1, mv2, ind;
  logic [ADDR_W-1:0] sum;
  assign take      = I_INSN_VALID && O_INSN_READY;
  assign push_take = take && !wait_reg && I_INSN_WORD[15:8] == PUSH_OP;
  assign mv1       = take && !wait_reg && I_INSN_WORD[15:7] == MOVE_OP;
  assign mv2       = take && wait_reg && I_INSN_WORD[15:12] == SECOND_OP;
  assign sum       = O_PTR + {5'h00, I_INSN_WORD[6:0]};
  // indirect registers sit at the top of the space
  assign ind       = sum >= IND_ADDR0;
  // source indirection is remembered from the first word for the data check
  always_ff @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      wait_reg    <= 1'b0;
      src_ind_reg <= 1'b0;
    end else begin
      if (mv1 || mv2) begin
        wait_reg <= mv1;
      end
      if (mv1) begin
        src_ind_reg <= ind;
      end
    end
  end
  // ***************************************
  // properties
  // ***************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  property p_push_store;
    push_take |=> O_MEM_WE && O_DONE && O_MEM_WDATA == $past(I_INSN_WORD[7:0])
      && O_MEM_ADDR == $past(O_PTR);
  endproperty
  property p_push_dec;
    push_take |=> O_PTR == $past(O_PTR) - PTR_STEP;
  endproperty
  property p_src_addr;
    mv1 |=> O_MEM_ADDR == $past(sum) && O_MEM_RE == !$past(ind);
  endproperty
  property p_re_cause;
    O_MEM_RE |-> $past(mv1);
  endproperty
  property p_ready_slot;
    mv2 |=> !O_INSN_READY ##1 O_INSN_READY;
  endproperty
  property p_move_write;
    mv2 && !ind |-> ##2 O_MEM_WE && O_DONE && O_MEM_ADDR == $past(sum, 2);
  endproperty
  property p_move_data;
    mv2 && !ind |-> ##2 O_MEM_WDATA == (src_ind_reg ? 8'h00 : $past(I_MEM_RDATA));
  endproperty
  property p_dst_nop;
    mv2 && ind |-> ##2 O_MOVE_NOP && O_DONE && !O_MEM_WE;
  endproperty
  property p_we_cause;
    O_MEM_WE |-> $past(push_take) || $past(mv2, 2);
  endproperty
  a_push_store: assert property (p_push_store) else $error("push store wrong");
  a_push_dec: assert property (p_push_dec) else $error("pointer step wrong");
  a_src_addr: assert property (p_src_addr) else $error("source access wrong");
  a_re_cause: assert property (p_re_cause) else $error("stray read");
  a_ready_slot: assert property (p_ready_slot) else $error("write slot wrong");
  a_move_write: assert property (p_move_write) else $error("move write wrong");
  a_move_data: assert property (p_move_data) else $error("move data wrong");
  a_dst_nop: assert property (p_dst_nop) else $error("dropped move wrong");
  a_we_cause: assert property (p_we_cause) else $error("stray write");
  c_push: cover property (push_take);
  c_move: cover property (mv2 && !ind);
  c_nop: cover property (mv2 && ind);
endmodule : imp_exec_asserts
bind imp_exec imp_exec_asserts u_chk (
  .I_CLK, .I_RST_N, .I_INSN_VALID, .I_INSN_WORD, .O_INSN_READY, .O_PTR, .I_MEM_RDATA,
  .O_MEM_ADDR, .O_MEM_RE, .O_MEM_WE, .O_MEM_WDATA, .O_DONE, .O_MOVE_NOP
);
`default_nettype wire

/* imp_exec_tb.sv */
// self-checking bench for the indexed move and push execution block
`default_nettype none
module imp_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] IND = imp_pkg::IND_ADDR0;
  logic        clk   = 1'b0;
  logic        rst_n = 1'b0;
  logic        valid = 1'b0;
  logic [15:0] word  = 16'h0000;
  logic        ptr_we = 1'b0;
  logic [11:0] ptr_wd = 12'h000;
  logic [7:0]  rdata = 8'h00;
  logic        ready, re, we, done, nop;
  logic [11:0] ptr, addr;
  logic [7:0]  wdata;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  imp_exec i_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_INSN_VALID(valid), .I_INSN_WORD(word),
    .O_INSN_READY(ready), .I_PTR_WE(ptr_we), .I_PTR_WDATA(ptr_wd), .O_PTR(ptr),
    .O_MEM_ADDR(addr), .O_MEM_RE(re), .O_MEM_WE(we), .O_MEM_WDATA(wdata),
    .I_MEM_RDATA(rdata), .O_DONE(done), .O_MOVE_NOP(nop)
  );
  always #5 clk = ~clk;
  // memory answers a read with a value tied to its address, and holds it
  always @(negedge clk) if (re) rdata <= addr[7:0] ^ 8'h5a;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 1000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic set_ptr(input logic [11:0] p);
    @(negedge clk);
    ptr_we = 1'b1;
    ptr_wd = p;
    @(negedge clk);
    ptr_we = 1'b0;
  endtask : set_ptr
  task automatic do_push(input logic [11:0] p, input logic [7:0] k);
    set_ptr(p);
    valid = 1'b1;
    word = {8'hfa, k};
    @(negedge clk);
    valid = 1'b0;
    chk(we, 1'b1);
    chk(addr, p);
    chk(wdata, k);
    chk(ptr, p - 12'h001);
    chk(done, 1'b1);
  endtask : do_push
  task automatic do_move(input logic [11:0] p, input logic [6:0] zs, zd);
    logic [11:0] s, d;
    logic [7:0]  v;
    s = p + {5'h00, zs};
    d = p + {5'h00, zd};
    v = (s >= IND) ? 8'h00 : s[7:0] ^ 8'h5a;
    set_ptr(p);
    valid = 1'b1;
    word = {9'h1d7, zs};
    @(negedge clk);
    chk(re, s < IND);
    if (s < IND) chk(addr, s);
    word = {4'hf, 5'h00, zd};
    @(negedge clk);
    valid = 1'b0;
    chk(ready, 1'b0);
    @(negedge clk);
    chk(we, d < IND);
    chk(nop, d >= IND);
    chk(done, 1'b1);
    if (d < IND) chk(addr, d);
    if (d < IND) chk(wdata, v);
  endtask : do_move
  task automatic t_push();
    do_push(12'h1ec, 8'h08);
    do_push(12'h000, 8'hff);
    $display("push test done");
  endtask : t_push
  task automatic t_move();
    do_move(12'h080, 7'h05, 7'h06);
    do_move(12'hff0, 7'h0c, 7'h7f);
    do_move(12'h000, 7'h7f, 7'h00);
    $display("move test done");
  endtask : t_move
  task automatic t_indirect();
    do_move(12'hf80, 7'h7d, 7'h10);
    do_move(12'hf90, 7'h01, 7'h6f);
    $display("indirect test done");
  endtask : t_indirect
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    t_push();
    t_move();
    t_indirect();
    tally_and_finish();
  end
endmodule : imp_exec_tb
`default_nettype wire
